//--- ioc_pkg.sv
// Package of the IO configuration bank: offsets, field layouts, resets.
// Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
package ioc_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 12; // Byte address width
	localparam int DATA_W = 32; // Bus data width
	localparam int IDX_W = 8; // Register index width

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_CFG_ONE = 8'h00; // First IO config
	localparam logic [IDX_W-1:0] IDX_CFG_TWO = 8'h01; // Second IO config
	localparam logic [IDX_W-1:0] IDX_OP_CTRL = 8'h02; // Operation control
	localparam logic [IDX_W-1:0] IDX_STATUS = 8'h03; // Block status view

	// ------------------------------------------------------------
	// Reset values and masks
	// ------------------------------------------------------------
	localparam logic [7:0] CFG_ONE_RST = 8'h00; // First config at reset
	localparam logic [7:0] CFG_TWO_RST = 8'h00; // Second config at reset
	localparam logic [7:0] OP_CTRL_RST = 8'h00; // Op control at reset
	localparam logic [7:0] CFG_ONE_WMASK = 8'hf7; // Reserved bit 3 held 0
	localparam logic [7:0] OP_CTRL_WMASK = 8'h80; // Only main enable kept
	localparam int OP_MAIN_EN_BIT = 7; // Main enable position

	// ------------------------------------------------------------
	// Bus responses
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0; // Normal access
	localparam logic [1:0] RESP_DECERR = 2'h3; // Unmapped address

	// ------------------------------------------------------------
	// Host clock divider codes and half-period tick counts
	// ------------------------------------------------------------
	localparam logic [1:0] DIV_3M39 = 2'h0; // 3.39 MHz
	localparam logic [1:0] DIV_6M78 = 2'h1; // 6.78 MHz
	localparam logic [1:0] DIV_13M56 = 2'h2; // 13.56 MHz
	localparam logic [1:0] DIV_OFF = 2'h3; // Output held low
	localparam logic [2:0] HALF_3M39 = 3'h4; // Ticks per half period
	localparam logic [2:0] HALF_6M78 = 3'h2; // Ticks per half period
	localparam logic [2:0] HALF_13M56 = 3'h1; // Ticks per half period
	localparam logic [2:0] HALF_SLOW = 3'h1; // Slow tick per half period
	localparam logic [2:0] DIV_CNT_RST = 3'h0; // Divider count at reset

	// ------------------------------------------------------------
	// Register layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic single_drive; // 1: one driver only
		logic alt_driver_pair_select; // 1: second driver/input pair
		logic [1:0] i2c_hold_select; // Hold time, stored only
		logic reserved; // Reads zero
		logic [1:0] host_clock_divider; // Host clock frequency code
		logic slow_clock_suppress; // 1: no slow clock
	} ioc_cfg_one_type;

	typedef struct packed {
		logic low_supply_select; // Supply range, stored only
		logic regulator_off; // 1: digital regulator off
		logic tuning_enable; // Tuning converter enable
		logic sdo_pulldown_selected; // Pull-down while selected
		logic sdo_pulldown_deselected; // Pull-down while deselected
		logic drive_boost; // Stronger IO drivers
		logic modulation_ref_select; // 1: reference from RF supply
		logic active_sink; // Active sink on modulation supply
	} ioc_cfg_two_type;

	typedef struct packed {
		logic xtal_running; // Crystal oscillator runs
		logic host_clk; // Host clock level
		logic tuning_active; // Tuning converters running
		logic tuning_hold; // Tuning outputs fixed
		logic sdo_pulldown; // Pull-down on serial out
		logic enable_seen; // Main enable was ever set
		logic spi_mode; // Serial interface is SPI
		logic serial_select_n; // Chip select level
	} ioc_status_type;

endpackage

//--- ioc_tick_divider.sv
// Tick-driven toggle divider for the host clock output.
// Assumes tick is a one-cycle pulse synchronous to aclk.
`timescale 1ns/1ns
module ioc_tick_divider
	import ioc_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic clear, // Hold output low, restart count
	input wire logic tick, // Reference half-period event
	input wire logic [2:0] half_ticks, // Ticks per output half period
	output logic clk_out // Divided clock level
);

	// ------------------------------------------------------------
	// Counter and toggle
	// ------------------------------------------------------------
	logic [2:0] cnt_q; // Ticks seen this half period
	logic [2:0] cnt_next; // Incremented count
	logic wrap; // Half period complete

	assign cnt_next = cnt_q + 3'h1;
	assign wrap = tick && (cnt_next >= half_ticks);

	// Count ticks, toggle when a half period completes
	always_ff @(posedge aclk)
	begin
		if (!aresetn || clear)
		begin
			cnt_q <= DIV_CNT_RST;
			clk_out <= 1'b0;
		end
		else if (wrap)
		begin
			cnt_q <= DIV_CNT_RST;
			clk_out <= !clk_out;
		end
		else if (tick)
		begin
			cnt_q <= cnt_next;
		end
	end

endmodule

//--- ioc_config_bank.sv
// IO configuration bank: two config registers, main enable, host clock.
// Assumes an AXI4-Lite master and tick pulses from the oscillators.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
// Operation
// (RL1) Bit 7 picks differential or single driving
// (RL2) Bit 6 picks driver pair when single
// (RL3) Divider codes give 3.39/6.78/13.56 MHz
// (RL4) Code 11 holds host clock low
// (RL5) Slow clock when crystal stopped, unless suppressed
// (RL6) Tuning converters need tuning and main enable
// (RL7) Host sets main enable once before relying
// (RL8) SPI pull-down while selected and undriven
// (RL9) Pull-down while chip select high
// (RL10) Bit 2 raises IO drive strength
// (RL11) Bit 6 switches digital regulator off
// (RL12) Bit 1 picks modulation regulator reference
// (RL13) Host enables active sink with big capacitor
// (RL14) Main enable starts oscillator and regulators
// (RL15) Reset to zero, reserved bit reads zero
module ioc_config_bank
	import ioc_pkg::*;
(
	input wire logic aclk, // System clock, 20 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Write protection, unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [DATA_W-1:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Read protection, unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [DATA_W-1:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic xtal_running, // Crystal oscillator runs
	input wire logic xtal_tick, // 13.56 MHz half-period event
	input wire logic slow_tick, // 32 kHz half-period event
	input wire logic spi_mode, // Serial interface is SPI
	input wire logic serial_select_n, // Chip select, active low
	input wire logic sdo_driving, // Device drives serial out
	output logic single_drive, // One antenna driver only
	output logic alt_driver_pair_select, // Second pair in use
	output logic [1:0] i2c_hold_select, // Hold time setting
	output logic host_clk_out, // Host clock output level
	output logic drive_boost, // Stronger IO drivers
	output logic sdo_pulldown_en, // Pull-down on serial out
	output logic regulator_off, // Digital regulator off
	output logic low_supply_select, // Supply range setting
	output logic modulation_ref_select, // Regulator reference
	output logic active_sink_en, // Active sink enabled
	output logic tuning_dac_active, // Tuning converters running
	output logic tuning_dac_hold, // Tuning outputs fixed
	output logic main_enable // Oscillator, regulators, ready
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	ioc_cfg_one_type cfg_one_q; // First IO config
	ioc_cfg_two_type cfg_two_q; // Second IO config
	logic [7:0] op_ctrl_q; // Operation control
	logic enable_seen_q; // Main enable was set once
	logic host_clk_q; // Registered host clock
	logic host_clk_d; // Next host clock
	logic dac_active_q; // Tuning converters running
	logic dac_hold_q; // Tuning outputs fixed
	logic pulldown_q; // Pull-down state
	logic pulldown_d; // Next pull-down state
	logic bvalid_q; // Write response pending
	logic [1:0] bresp_q; // Write response code
	logic rvalid_q; // Read data pending
	logic [1:0] rresp_q; // Read response code
	logic [DATA_W-1:0] rdata_q; // Read data
	ioc_status_type status; // Live status view

	// ------------------------------------------------------------
	// Write address decode
	// ------------------------------------------------------------
	logic wr_take; // Address and data taken together
	logic [IDX_W-1:0] wr_idx; // Word index written
	logic wr_high_zero; // Upper address bits clear
	logic wr_cfg_one; // Hit on first config
	logic wr_cfg_two; // Hit on second config
	logic wr_op_ctrl; // Hit on operation control
	logic wr_status; // Hit on read-only status
	logic wr_mapped; // Any known register
	logic wr_lane0; // Low byte lane enabled

	assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign wr_idx = s_axi_awaddr[IDX_W+1:2];
	assign wr_high_zero = (s_axi_awaddr[ADDR_W-1:IDX_W+2] == '0);
	assign wr_cfg_one = wr_high_zero && (wr_idx == IDX_CFG_ONE);
	assign wr_cfg_two = wr_high_zero && (wr_idx == IDX_CFG_TWO);
	assign wr_op_ctrl = wr_high_zero && (wr_idx == IDX_OP_CTRL);
	assign wr_status = wr_high_zero && (wr_idx == IDX_STATUS);
	assign wr_mapped = wr_cfg_one || wr_cfg_two || wr_op_ctrl || wr_status;
	assign wr_lane0 = wr_take && s_axi_wstrb[0];

	// ------------------------------------------------------------
	// Read address decode
	// ------------------------------------------------------------
	logic rd_take; // Read address taken
	logic [IDX_W-1:0] rd_idx; // Word index read
	logic rd_high_zero; // Upper address bits clear
	logic rd_mapped; // Known register
	logic [7:0] rd_byte; // Selected register value

	assign rd_take = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = rd_take;
	assign rd_idx = s_axi_araddr[IDX_W+1:2];
	assign rd_high_zero = (s_axi_araddr[ADDR_W-1:IDX_W+2] == '0);
	assign rd_mapped = rd_high_zero && (rd_idx <= IDX_STATUS);
	assign rd_byte = !rd_high_zero ? 8'h00 :
		(rd_idx == IDX_CFG_ONE) ? (cfg_one_q & CFG_ONE_WMASK) : // RL15
		(rd_idx == IDX_CFG_TWO) ? cfg_two_q :
		(rd_idx == IDX_OP_CTRL) ? op_ctrl_q :
		(rd_idx == IDX_STATUS) ? status : 8'h00;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Config and control update on an accepted low-lane write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_one_q <= CFG_ONE_RST; // RL15
			cfg_two_q <= CFG_TWO_RST; // RL15
			op_ctrl_q <= OP_CTRL_RST;
		end
		else if (wr_lane0)
		begin
			if (wr_cfg_one)
				cfg_one_q <= s_axi_wdata[7:0] & CFG_ONE_WMASK; // RL15
			if (wr_cfg_two)
				cfg_two_q <= s_axi_wdata[7:0];
			if (wr_op_ctrl)
				op_ctrl_q <= s_axi_wdata[7:0] & OP_CTRL_WMASK;
		end
	end

	// ------------------------------------------------------------
	// Bus responses
	// ------------------------------------------------------------
	// Write response one cycle after the take
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_take)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? RESP_OKAY : RESP_DECERR;
		end
		else if (s_axi_bready)
		begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data captured at the address take
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end
		else if (rd_take)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_mapped ? RESP_OKAY : RESP_DECERR;
			rdata_q <= {24'h000000, rd_byte};
		end
		else if (s_axi_rready)
		begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// ------------------------------------------------------------
	// Host clock generation
	// ------------------------------------------------------------
	logic [1:0] div_code; // Selected divider code
	logic [2:0] xtal_half; // Ticks per half period
	logic clk_off; // Output disabled
	logic xtal_div_clk; // Divided crystal clock
	logic slow_clk; // Slow clock level

	assign div_code = cfg_one_q.host_clock_divider;
	assign clk_off = (div_code == DIV_OFF); // RL4
	assign xtal_half = (div_code == DIV_13M56) ? HALF_13M56 : // RL3
		(div_code == DIV_6M78) ? HALF_6M78 : HALF_3M39; // RL3

	// Crystal-derived divider, restarted when stopped or off
	ioc_tick_divider u_xtal_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(clk_off || !xtal_running),
		.tick(xtal_tick),
		.half_ticks(xtal_half),
		.clk_out(xtal_div_clk)
	);

	// Slow clock follows its own half-period ticks
	ioc_tick_divider u_slow_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(clk_off || xtal_running),
		.tick(slow_tick),
		.half_ticks(HALF_SLOW),
		.clk_out(slow_clk)
	);

	// Source select: off, crystal, slow, or held low
	assign host_clk_d = clk_off ? 1'b0 : // RL4
		xtal_running ? xtal_div_clk : // RL3
		!cfg_one_q.slow_clock_suppress ? slow_clk : 1'b0; // RL5

	// ------------------------------------------------------------
	// Tuning converters, pull-downs, main enable
	// ------------------------------------------------------------
	assign main_enable = op_ctrl_q[OP_MAIN_EN_BIT]; // RL14

	// Serial out pull-down per chip select level
	assign pulldown_d = (spi_mode && !serial_select_n && !sdo_driving &&
		cfg_two_q.sdo_pulldown_selected) || // RL8
		(serial_select_n && cfg_two_q.sdo_pulldown_deselected); // RL9

	// Derived outputs registered
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			host_clk_q <= 1'b0;
			enable_seen_q <= 1'b0;
			dac_active_q <= 1'b0;
			dac_hold_q <= 1'b0;
			pulldown_q <= 1'b0;
		end
		else
		begin
			host_clk_q <= host_clk_d;
			enable_seen_q <= enable_seen_q || main_enable;
			dac_active_q <= cfg_two_q.tuning_enable && main_enable; // RL6
			dac_hold_q <= cfg_two_q.tuning_enable && !main_enable &&
				enable_seen_q; // RL6
			pulldown_q <= pulldown_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs and status
	// ------------------------------------------------------------
	assign single_drive = cfg_one_q.single_drive; // RL1
	assign alt_driver_pair_select = cfg_one_q.single_drive &&
		cfg_one_q.alt_driver_pair_select; // RL2
	assign i2c_hold_select = cfg_one_q.i2c_hold_select;
	assign host_clk_out = host_clk_q;
	assign drive_boost = cfg_two_q.drive_boost; // RL10
	assign sdo_pulldown_en = pulldown_q;
	assign regulator_off = cfg_two_q.regulator_off; // RL11
	assign low_supply_select = cfg_two_q.low_supply_select;
	assign modulation_ref_select = cfg_two_q.modulation_ref_select; // RL12
	assign active_sink_en = cfg_two_q.active_sink;
	assign tuning_dac_active = dac_active_q;
	assign tuning_dac_hold = dac_hold_q;

	assign status.xtal_running = xtal_running;
	assign status.host_clk = host_clk_q;
	assign status.tuning_active = dac_active_q;
	assign status.tuning_hold = dac_hold_q;
	assign status.sdo_pulldown = pulldown_q;
	assign status.enable_seen = enable_seen_q;
	assign status.spi_mode = spi_mode;
	assign status.serial_select_n = serial_select_n;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [IDX_W-1:0] rd_idx_q; // Index of last read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_idx_q <= '0;
		else if (rd_take)
			rd_idx_q <= rd_idx;
	end

	property p_single_write;
		(wr_lane0 && wr_cfg_one) |=>
			(single_drive == $past(s_axi_wdata[7]));
	endproperty
	a_single_write: assert property (p_single_write) // RL1
		else $error("single drive not taken from write");

	property p_pair_gated;
		alt_driver_pair_select |-> single_drive;
	endproperty
	a_pair_gated: assert property (p_pair_gated) // RL2
		else $error("pair select active in differential mode");

	property p_xtal_clock;
		(xtal_running && !clk_off) |=> (host_clk_out == $past(xtal_div_clk));
	endproperty
	a_xtal_clock: assert property (p_xtal_clock) // RL3
		else $error("host clock not from crystal divider");

	property p_clock_off;
		clk_off [*2] |-> (host_clk_out == 1'b0);
	endproperty
	a_clock_off: assert property (p_clock_off) // RL4
		else $error("host clock not low while disabled");

	property p_slow_clock;
		(!xtal_running && !clk_off) |=> (host_clk_out ==
			($past(cfg_one_q.slow_clock_suppress) ? 1'b0 : $past(slow_clk)));
	endproperty
	a_slow_clock: assert property (p_slow_clock) // RL5
		else $error("slow clock path wrong");

	property p_dac_gate;
		(cfg_two_q.tuning_enable && main_enable) |=>
			(tuning_dac_active && !tuning_dac_hold);
	endproperty
	a_dac_gate: assert property (p_dac_gate) // RL6
		else $error("tuning converters not active");

	property p_dac_idle;
		!$past(main_enable) |-> !tuning_dac_active;
	endproperty
	a_dac_idle: assert property (p_dac_idle) // RL6
		else $error("tuning active without main enable");

	property p_pulldown;
		(spi_mode && !serial_select_n && !sdo_driving &&
			cfg_two_q.sdo_pulldown_selected) |=> sdo_pulldown_en;
	endproperty
	a_pulldown: assert property (p_pulldown) // RL8
		else $error("pull-down did not follow select state");

	property p_pulldown_desel;
		(serial_select_n && cfg_two_q.sdo_pulldown_deselected) |=>
			sdo_pulldown_en;
	endproperty
	a_pulldown_desel: assert property (p_pulldown_desel) // RL9
		else $error("pull-down missing while deselected");

	property p_reserved_zero;
		(s_axi_rvalid && rd_idx_q == IDX_CFG_ONE) |-> !s_axi_rdata[3];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // RL15
		else $error("reserved bit read back nonzero");

	property p_enable_write;
		(wr_lane0 && wr_op_ctrl) |=>
			(main_enable == $past(s_axi_wdata[OP_MAIN_EN_BIT]));
	endproperty
	a_enable_write: assert property (p_enable_write) // RL14
		else $error("main enable not taken from write");

endmodule

//--- ioc_osc_model.sv
// Oscillator model: tick pulses that feed the host clock divider.
// Assumes xtal_running is driven by the bench on the same clock.
`timescale 1ns/1ns
module ioc_osc_model
#(
	parameter int XTAL_GAP = 2, // Cycles between crystal ticks
	parameter int SLOW_GAP = 8 // Cycles between slow ticks
)
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic xtal_running, // Crystal oscillator runs
	output logic xtal_tick, // Crystal half-period event
	output logic slow_tick // Slow clock half-period event
);
	// ------------------------------------------------------------
	// Tick generation
	// ------------------------------------------------------------
	logic [3:0] cnt_q; // Free running cycle count
	// Count cycles; the wrap keeps both tick gaps even
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_q + 4'h1;
	end
	// A stopped crystal gives no ticks, only the slow source runs
	assign xtal_tick = xtal_running && (32'(cnt_q) % XTAL_GAP == 0);
	assign slow_tick = !xtal_running && (32'(cnt_q) % SLOW_GAP == 0);
endmodule

//--- io_configuration_registers_test.sv
// Self-checking bench of the IO configuration bank over AXI4-Lite.
// Assumes ioc_pkg, ioc_config_bank and ioc_osc_model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	failures++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module io_configuration_registers_test
	import ioc_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, xtal_running;
	logic xtal_tick, slow_tick, spi_mode, serial_select_n, sdo_driving;
	logic single_drive, alt_driver_pair_select, host_clk_out, drive_boost;
	logic sdo_pulldown_en, regulator_off, low_supply_select;
	logic modulation_ref_select, active_sink_en, tuning_dac_active;
	logic tuning_dac_hold, main_enable;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr; // Byte addresses
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata; // Data words
	logic [3:0] s_axi_wstrb; // Byte strobes
	logic [1:0] s_axi_bresp, s_axi_rresp, i2c_hold_select; // Codes
	int failures, samples_checked, cycles; // Bench counters

	// ------------------------------------------------------------
	// Design and oscillator model
	// ------------------------------------------------------------
	ioc_config_bank dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .xtal_running(xtal_running),
		.xtal_tick(xtal_tick), .slow_tick(slow_tick), .spi_mode(spi_mode),
		.serial_select_n(serial_select_n), .sdo_driving(sdo_driving),
		.single_drive(single_drive),
		.alt_driver_pair_select(alt_driver_pair_select),
		.i2c_hold_select(i2c_hold_select), .host_clk_out(host_clk_out),
		.drive_boost(drive_boost), .sdo_pulldown_en(sdo_pulldown_en),
		.regulator_off(regulator_off),
		.low_supply_select(low_supply_select),
		.modulation_ref_select(modulation_ref_select),
		.active_sink_en(active_sink_en),
		.tuning_dac_active(tuning_dac_active),
		.tuning_dac_hold(tuning_dac_hold), .main_enable(main_enable));
	ioc_osc_model osc (.aclk(aclk), .aresetn(aresetn),
		.xtal_running(xtal_running), .xtal_tick(xtal_tick),
		.slow_tick(slow_tick));

	// ------------------------------------------------------------
	// Clock, watchdog and verdict
	// ------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Cut a hang short after far more cycles than the tests need
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("failures=%0d samples_checked=%0d", failures,
			samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	// One write; address and data offered together, held until taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] st, output logic [1:0] rsp);
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// One read; response held by rready until rvalid is seen
	task automatic rd(input logic [7:0] idx, output logic [31:0] v,
		output logic [1:0] rsp);
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Full write expecting OKAY, then let derived outputs settle
	task automatic w(input logic [7:0] idx, input logic [7:0] d);
		logic [1:0] r;
		wr(idx, d, 4'hf, r);
		`CHK(r, RESP_OKAY);
		repeat (3) @(posedge aclk);
	endtask
	// Read expecting OKAY and the given byte
	task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
		logic [31:0] v;
		logic [1:0] r;
		rd(idx, v, r);
		`CHK(v, {24'h0, e});
		`CHK(r, RESP_OKAY);
	endtask
	// Host clock period, rising edge to rising edge, in cycles
	task automatic per(output int n);
		n = 0;
		do @(posedge aclk); while (host_clk_out !== 1'b0);
		do @(posedge aclk); while (host_clk_out !== 1'b1);
		do begin @(posedge aclk); n++; end while (host_clk_out !== 1'b0);
		do begin @(posedge aclk); n++; end while (host_clk_out !== 1'b1);
	endtask
	// Host clock must stay low over a long window
	task automatic stays_low();
		logic hi;
		hi = 1'b0;
		repeat (40) begin @(posedge aclk); hi |= host_clk_out; end
		`CHK(hi, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		int c, k, n;
		logic [31:0] v;
		logic [1:0] r;
		logic [7:0] d;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, spi_mode, sdo_driving} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h0;
		serial_select_n = 1'b1;
		xtal_running = 1'b1;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (c = 0; c < 3; c++) chk_rd(c[7:0], 8'h00);
		w(8'h00, 8'hff);
		chk_rd(8'h00, 8'hf7);
		`CHK({single_drive, alt_driver_pair_select}, 2'h3);
		`CHK(i2c_hold_select, 2'h3);
		w(8'h00, 8'h80);
		`CHK({single_drive, alt_driver_pair_select}, 2'h2);
		w(8'h00, 8'h40);
		`CHK({single_drive, alt_driver_pair_select}, 2'h0);
		wr(8'h00, 8'hff, 4'he, r);
		`CHK(r, RESP_OKAY);
		chk_rd(8'h00, 8'h40);
		wr(8'h04, 8'hff, 4'hf, r);
		`CHK(r, RESP_DECERR);
		rd(8'h04, v, r);
		`CHK({v, r}, {32'h0, RESP_DECERR});
		for (c = 0; c < 8; c++)
		begin
			d = 8'h01 << c;
			w(8'h01, d);
			chk_rd(8'h01, d);
			`CHK({low_supply_select, regulator_off, drive_boost,
				modulation_ref_select, active_sink_en},
				{d[7], d[6], d[2], d[1], d[0]});
		end
		for (c = 0; c < 4; c++)
		begin
			w(8'h01, {3'h0, c[1:0], 3'h0});
			for (k = 0; k < 8; k++)
			begin
				{sdo_driving, serial_select_n, spi_mode} <= k[2:0];
				repeat (2) @(posedge aclk);
				`CHK(sdo_pulldown_en, (c[1] & k[0] & !k[1] & !k[2])
					| (c[0] & k[1]));
			end
		end
		w(8'h01, 8'h20);
		`CHK({tuning_dac_active, tuning_dac_hold}, 2'h0);
		w(8'h02, 8'hff);
		chk_rd(8'h02, 8'h80);
		`CHK({main_enable, tuning_dac_active}, 2'h3);
		w(8'h02, 8'h00);
		`CHK({main_enable, tuning_dac_active, tuning_dac_hold},
			3'h1);
		for (c = 0; c < 3; c++)
		begin
			w(8'h00, {5'h0, c[1:0], 1'b0});
			per(n);
			`CHK(n, 16 >> c);
		end
		w(8'h00, 8'h06);
		stays_low();
		xtal_running <= 1'b0;
		w(8'h00, 8'h00);
		per(n);
		`CHK(n, 16);
		w(8'h00, 8'h01);
		stays_low();
		w(8'h00, 8'h06);
		stays_low();
		w(8'h03, 8'hff);
		chk_rd(8'h03, 8'h17);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_rd(8'h00, 8'h00);
		`CHK({tuning_dac_hold, main_enable}, 2'h0);
		end_of_test();
	end
endmodule
